// ---- design/cbx_pkg.sv ----
// Package for the branch and increment/decrement execution slice
package cbx_pkg;
  localparam logic [7:0] CBX_ACC_RST = 8'h00;
  localparam logic [9:0] CBX_PC_RST = 10'h000;
  localparam logic CBX_GIE_RST = 1'b0;
  localparam logic CBX_Z_RST = 1'b0;
  localparam int CBX_PC_HI_BIT = 9;
  localparam int CBX_PAGE_BIT = 1;
  localparam logic [7:0] CBX_ONE = 8'h01;
  localparam logic [9:0] CBX_PC_ONE = 10'h001;

  typedef enum logic [2:0] {
    CBX_OP_NONE,
    CBX_OP_DEC_SKIP,
    CBX_OP_INC,
    CBX_OP_IRQ_OFF,
    CBX_OP_IRQ_ON,
    CBX_OP_JUMP_IMM,
    CBX_OP_JUMP_COMP
  } cbx_op_e;

  typedef struct packed {
    cbx_op_e op;
    logic dest_reg;
    logic [8:0] addr;
  } cbx_instr_s;

  typedef struct packed {
    logic we;
    logic [7:0] data;
  } cbx_rf_wr_s;

  typedef enum logic [1:0] {
    CBX_ST_EXEC,
    CBX_ST_FLUSH
  } cbx_state_e;
endpackage

// ---- design/cbx_exec.sv ----
// Execution slice: decrement-skip, increment, irq on/off, immediate and computed jumps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module cbx_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded instruction, valid once per cycle when instr_valid
  input wire logic instr_valid,
  input var cbx_pkg::cbx_instr_s instr,
  // Register file read data for the addressed register
  input wire logic [7:0] reg_rdata,
  // Page and table pointers
  input wire logic [1:0] pc_page_buffer,
  input wire logic [1:0] table_high_pointer,
  // Register file write-back
  output var cbx_pkg::cbx_rf_wr_s reg_wr,
  // Architectural state
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic global_irq_enable,
  output logic [9:0] pc,
  // Pipeline control
  output logic flush_next,
  output logic busy
);
  import cbx_pkg::*;

  cbx_state_e state_q;
  logic [7:0] acc_q;
  logic z_q;
  logic gie_q;
  logic [9:0] pc_q;
  cbx_rf_wr_s wr_q;
  logic [7:0] result;
  logic take;
  logic is_dec;
  logic is_inc;
  logic is_jump;
  logic skip;

  assign take = instr_valid && (state_q == CBX_ST_EXEC);
  assign is_dec = take && (instr.op == CBX_OP_DEC_SKIP);
  assign is_inc = take && (instr.op == CBX_OP_INC);
  assign is_jump = take && ((instr.op == CBX_OP_JUMP_IMM) || (instr.op == CBX_OP_JUMP_COMP));
  // 8-bit result wraps naturally
  assign result = is_dec ? (reg_rdata - CBX_ONE) : (reg_rdata + CBX_ONE);
  assign skip = is_dec && (result == 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // Second cycle of skip and jumps: the already fetched word is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CBX_ST_EXEC;
    end else if (skip || is_jump) begin
      state_q <= CBX_ST_FLUSH;
    end else begin
      state_q <= CBX_ST_EXEC;
    end
  end

  assign flush_next = skip || is_jump;
  assign busy = (state_q == CBX_ST_FLUSH);

  //////////////////////////////////////////////////////////////////////////////
  // Result destination
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= CBX_ACC_RST;
      wr_q <= '0;
    end else begin
      wr_q.we <= (is_dec || is_inc) && instr.dest_reg;
      wr_q.data <= result;
      if ((is_dec || is_inc) && !instr.dest_reg) begin
        acc_q <= result;
      end
    end
  end

  // Zero flag: only increment touches it; decrement-skip and jumps keep it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      z_q <= CBX_Z_RST;
    end else if (is_inc) begin
      z_q <= (result == 8'h00);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gie_q <= CBX_GIE_RST;
    end else if (take && instr.op == CBX_OP_IRQ_OFF) begin
      gie_q <= 1'b0;
    end else if (take && instr.op == CBX_OP_IRQ_ON) begin
      gie_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program counter; a nop slot advances it like any word other than a jump
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= CBX_PC_RST;
    end else if (take && instr.op == CBX_OP_JUMP_IMM) begin
      pc_q <= {pc_page_buffer[CBX_PAGE_BIT], instr.addr};
    end else if (take && instr.op == CBX_OP_JUMP_COMP) begin
      pc_q <= {table_high_pointer, acc_q};
    end else if (take || busy) begin
      pc_q <= pc_q + CBX_PC_ONE;
    end
  end

  assign accumulator = acc_q;
  assign zero_flag = z_q;
  assign global_irq_enable = gie_q;
  assign pc = pc_q;
  assign reg_wr = wr_q;

  //////////////////////////////////////////////////////////////////////////////
  a_skip_flush: assert property (@(posedge clk) disable iff (rst)
    skip |=> busy ##1 !busy) else $error("skip did not take two cycles");
  a_noskip_one: assert property (@(posedge clk) disable iff (rst)
    (is_dec && result != 8'h00) |=> !busy) else $error("decrement stalled");
  a_dec_zero: assert property (@(posedge clk) disable iff (rst)
    is_dec |-> (flush_next == (reg_rdata == 8'h01))) else $error("bad skip");
  a_dec_dest: assert property (@(posedge clk) disable iff (rst)
    (is_dec && !instr.dest_reg) |=> accumulator == $past(reg_rdata) - 8'h01)
    else $error("decrement result wrong");
  a_inc_wrap: assert property (@(posedge clk) disable iff (rst)
    (is_inc && reg_rdata == 8'hff) |=> zero_flag && reg_wr.data == 8'h00)
    else $error("increment wrap wrong");
  a_inc_reg: assert property (@(posedge clk) disable iff (rst)
    (is_inc && instr.dest_reg) |=> reg_wr.we && !busy) else $error("increment write");
  a_irq_off: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_IRQ_OFF) |=> !global_irq_enable) else $error("irq off");
  a_irq_on: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_IRQ_ON) |=> global_irq_enable) else $error("irq on");
  a_jump_imm: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_IMM) |=>
    pc == {$past(pc_page_buffer[1]), $past(instr.addr)} && busy)
    else $error("immediate jump target");
  a_jump_comp: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_COMP) |=>
    pc == {$past(table_high_pointer), $past(acc_q)} && $stable(zero_flag))
    else $error("computed jump target");

  //////////////////////////////////////////////////////////////////////////////
  // Field-level checks; each pins one rule so a failure names the broken path
  a_dec_reg: assert property (@(posedge clk) disable iff (rst)
    (is_dec && instr.dest_reg) |=> reg_wr.we && reg_wr.data == $past(reg_rdata) - 8'h01)
    else $error("decrement write-back wrong");
  a_dec_acc_keep: assert property (@(posedge clk) disable iff (rst)
    (is_dec && instr.dest_reg) |=> $stable(accumulator))
    else $error("decrement to register touched accumulator");
  a_dec_keep_z: assert property (@(posedge clk) disable iff (rst)
    is_dec |=> $stable(zero_flag))
    else $error("decrement-skip changed zero flag");
  a_dec_wrap: assert property (@(posedge clk) disable iff (rst)
    (is_dec && reg_rdata == 8'h00) |=> reg_wr.data == 8'hff)
    else $error("decrement wrap wrong");
  a_dec_noskip: assert property (@(posedge clk) disable iff (rst)
    (is_dec && reg_rdata != 8'h01) |-> !flush_next)
    else $error("decrement flushed without zero");
  a_dead_slot: assert property (@(posedge clk) disable iff (rst)
    busy |-> !flush_next)
    else $error("discarded word acted on");
  a_inc_acc: assert property (@(posedge clk) disable iff (rst)
    (is_inc && !instr.dest_reg) |=> accumulator == $past(reg_rdata) + 8'h01)
    else $error("increment to accumulator wrong");
  a_inc_zero: assert property (@(posedge clk) disable iff (rst)
    is_inc |=> zero_flag == ($past(reg_rdata) == 8'hff))
    else $error("increment zero flag wrong");
  a_inc_one: assert property (@(posedge clk) disable iff (rst)
    is_inc |-> !flush_next)
    else $error("increment flushed");
  a_irq_off_one: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_IRQ_OFF) |=> !busy)
    else $error("irq off took two cycles");
  a_irq_on_one: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_IRQ_ON) |=> !busy)
    else $error("irq on took two cycles");
  a_jump_imm_low: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_IMM) |=> pc[8:0] == $past(instr.addr))
    else $error("immediate jump low bits");
  a_jump_imm_high: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_IMM) |=> pc[CBX_PC_HI_BIT] == $past(pc_page_buffer[1]))
    else $error("immediate jump page bit");
  a_jump_imm_flags: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_IMM) |=> $stable(zero_flag) && $stable(accumulator))
    else $error("immediate jump changed state");
  a_jump_imm_two: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_IMM) |=> busy ##1 !busy)
    else $error("immediate jump not two cycles");
  a_jump_imm_flush: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_IMM) |-> flush_next)
    else $error("immediate jump kept fetched word");
  a_jump_no_write: assert property (@(posedge clk) disable iff (rst)
    is_jump |=> !reg_wr.we)
    else $error("jump wrote register");
  a_jump_comp_high: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_COMP) |=> pc[9:8] == $past(table_high_pointer))
    else $error("computed jump high bits");
  a_jump_comp_low: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_COMP) |=> pc[7:0] == $past(accumulator))
    else $error("computed jump low byte");
  a_jump_comp_two: assert property (@(posedge clk) disable iff (rst)
    (take && instr.op == CBX_OP_JUMP_COMP) |=> busy ##1 !busy)
    else $error("computed jump not two cycles");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the branch and increment/decrement execution slice
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cbx_pkg::*;
  logic clk, rst, instr_valid, zero_flag, global_irq_enable, flush_next, busy;
  cbx_instr_s instr;
  cbx_rf_wr_s reg_wr;
  logic [7:0] reg_rdata, accumulator;
  logic [1:0] pc_page_buffer, table_high_pointer;
  logic [9:0] pc;
  int errors = 0;
  int cmp_count = 0;
  cbx_exec uut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .reg_rdata(reg_rdata), .pc_page_buffer(pc_page_buffer),
    .table_high_pointer(table_high_pointer), .reg_wr(reg_wr), .accumulator(accumulator),
    .zero_flag(zero_flag), .global_irq_enable(global_irq_enable), .pc(pc),
    .flush_next(flush_next), .busy(busy));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One instruction: present it, check the flush strobe, let it be taken
  task automatic ex(cbx_op_e op, logic d, logic [8:0] a, logic [7:0] rd, logic [1:0] pb,
                    logic [1:0] tp, logic fl);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= cbx_instr_s'{op, d, a};
    reg_rdata <= rd;
    pc_page_buffer <= pb;
    table_high_pointer <= tp;
    #1 chk(flush_next, fl);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    reg_rdata = 8'h00;
    pc_page_buffer = 2'h0;
    table_high_pointer = 2'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk({accumulator, zero_flag, global_irq_enable}, 10'h000);
    chk({busy, pc}, 11'h000);
    ex(CBX_OP_IRQ_ON, 1'b0, 9'h000, 8'h00, 2'h0, 2'h0, 1'b0);
    chk(global_irq_enable, 1'b1);
    ex(CBX_OP_IRQ_OFF, 1'b0, 9'h000, 8'h00, 2'h0, 2'h0, 1'b0);
    chk(global_irq_enable, 1'b0);
    ex(CBX_OP_INC, 1'b0, 9'h003, 8'hff, 2'h0, 2'h0, 1'b0);
    chk({reg_wr.we, accumulator, zero_flag}, 10'h001);
    ex(CBX_OP_INC, 1'b1, 9'h004, 8'h41, 2'h0, 2'h0, 1'b0);
    chk({reg_wr, zero_flag}, {1'b1, 8'h42, 1'b0});
    // Skip taken: write-back of zero, dead slot follows, zero flag untouched
    ex(CBX_OP_DEC_SKIP, 1'b1, 9'h005, 8'h01, 2'h0, 2'h0, 1'b1);
    chk({reg_wr, busy, zero_flag}, {1'b1, 8'h00, 1'b1, 1'b0});
    chk(accumulator, 8'h00);
    ex(CBX_OP_DEC_SKIP, 1'b0, 9'h006, 8'h05, 2'h0, 2'h0, 1'b0);
    chk({reg_wr.we, busy, accumulator}, {1'b0, 1'b0, 8'h04});
    ex(CBX_OP_DEC_SKIP, 1'b0, 9'h006, 8'h00, 2'h0, 2'h0, 1'b0);
    chk(accumulator, 8'hff);
    ex(CBX_OP_INC, 1'b0, 9'h006, 8'h03, 2'h0, 2'h0, 1'b0);
    ex(CBX_OP_JUMP_IMM, 1'b0, 9'h1a5, 8'h00, 2'h2, 2'h0, 1'b1);
    chk({busy, pc}, {1'b1, 10'h3a5});
    ex(CBX_OP_JUMP_IMM, 1'b0, 9'h0ff, 8'h00, 2'h1, 2'h3, 1'b1);
    chk({busy, pc}, {1'b1, 10'h0ff});
    chk({accumulator, zero_flag}, 9'h008);
    ex(CBX_OP_JUMP_COMP, 1'b0, 9'h000, 8'h00, 2'h1, 2'h2, 1'b1);
    chk({busy, pc}, {1'b1, 10'h204});
    chk({accumulator, zero_flag}, 9'h008);
    ex(CBX_OP_JUMP_COMP, 1'b0, 9'h000, 8'h00, 2'h0, 2'h1, 1'b1);
    chk(pc, 10'h104);
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
